// ===== adc_spi_timing_and_latency_test.sv
// Purpose: end-to-end bench of the host end and the converter end
// Assumes: design inputs change at the falling clock edge
// Notes: frames at scale 1 to 3 keep the run short
module adc_spi_timing_and_latency_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clk_sys = 0, i_rst_b = 0, i_start = 0, i_read = 0, i_div_reset = 0, lat_on = 0;
	logic [7:0] i_scale = 8'h01, i_addr = 8'h00, i_wdata = 8'h00, o_cfg, o_rdata;
	logic [13:0] i_sample = 14'h0000, o_sample;
	logic o_cfg_wr, o_dll_locked, o_busy, o_done, seen_rise = 0;
	int bad_count = 0, n_checks = 0, n_wr = 0, setup_n = 0, dll_n = 0, n, m;
	// ****
	// rows: scale, read, address, write data, expected byte
	// ****
	localparam logic [32:0] ROWS [6] = '{{8'h01, 1'b0, 8'h10, 8'hA5, 8'hA5},
		{8'h01, 1'b1, 8'h10, 8'h00, 8'hA5}, {8'h02, 1'b0, 8'h22, 8'h3C, 8'h3C},
		{8'h02, 1'b1, 8'h55, 8'h00, 8'h3C}, {8'h01, 1'b1, 8'hB6, 8'h00, 8'h01},
		{8'h03, 1'b0, 8'h00, 8'h5A, 8'h5A}};
	ast_if ast_if_inst ();
	ast_dev ast_dev_inst (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .link(ast_if_inst),
		.i_sample(i_sample), .o_sample(o_sample), .o_cfg(o_cfg), .o_cfg_wr(o_cfg_wr),
		.o_dll_locked(o_dll_locked));
	ast_host ast_host_inst (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .link(ast_if_inst),
		.i_scale(i_scale), .i_start(i_start), .i_read(i_read), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_div_reset(i_div_reset), .o_busy(o_busy), .o_done(o_done),
		.o_rdata(o_rdata));
	ast_asserts ast_asserts_inst (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
		.port_select_n(ast_if_inst.port_select_n), .sclk(ast_if_inst.sclk),
		.sdio(ast_if_inst.sdio), .sdio_host_oe_n(ast_if_inst.sdio_host_oe_n),
		.sdio_dev_oe_n(ast_if_inst.sdio_dev_oe_n));
	always #20 i_clk_sys = ~i_clk_sys;
	task automatic check(input string name, input logic [15:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic give_verdict;
		if (bad_count == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : give_verdict
	// ****
	// wire monitors
	// ****
	always @(posedge i_clk_sys) begin
		n_wr <= n_wr + (o_cfg_wr === 1'b1);
		if (!ast_if_inst.port_select_n && !seen_rise) setup_n <= setup_n + 1;
		seen_rise <= !ast_if_inst.port_select_n && (seen_rise || ast_if_inst.sclk);
		if (ast_if_inst.divider_sync_reset_pos) dll_n <= 0;
		else if (o_dll_locked !== 1'b1) dll_n <= dll_n + 1;
	end
	always @(negedge i_clk_sys) begin
		// the value driven now is i_sample + 1, so ten falls back is that minus the latency
		if (lat_on) check("o_sample", o_sample,
			14'(i_sample + 14'h0001 - 14'(ast_pkg::LATENCY_CYCLES)));
		i_sample <= i_sample + 14'h0001;
	end
	task automatic xfer(input logic [7:0] sc, input logic rd, input logic [7:0] ad, wd);
		@(negedge i_clk_sys);
		{i_scale, i_read, i_addr, i_wdata, i_start} = {sc, rd, ad, wd, 1'b1};
		setup_n = 0;
		@(negedge i_clk_sys);
		i_start = 0;
		n = 0;
		while (o_done !== 1'b1 && n < 4000) begin
			@(negedge i_clk_sys);
			n++;
		end
		if (n >= 4000) begin
			bad_count++;
			give_verdict();
		end
	endtask : xfer
	initial begin
		repeat (12) @(negedge i_clk_sys);
		i_rst_b = 1;
		repeat (20) @(negedge i_clk_sys);
		lat_on = 1;
		foreach (ROWS[k]) begin
			m = n_wr;
			xfer(ROWS[k][32:25], ROWS[k][24], ROWS[k][23:16], ROWS[k][15:8]);
			@(negedge i_clk_sys);
			check("data", ROWS[k][24] ? o_rdata : o_cfg, ROWS[k][7:0]);
			check("writes", 16'(n_wr - m), {15'h0000, !ROWS[k][24]});
			check("setup", setup_n >= 28 * ROWS[k][32:25], 16'h0001);
		end
		// second start lands mid-frame and must be dropped
		fork
			xfer(8'h01, 1'b0, 8'h01, 8'h11);
			begin
				repeat (40) @(negedge i_clk_sys);
				{i_wdata, i_start} = {8'h77, 1'b1};
				@(negedge i_clk_sys);
				i_start = 0;
			end
		join
		repeat (60) @(negedge i_clk_sys);
		check("refused", {o_busy, o_cfg}, 16'h0011);
		i_div_reset = 1;
		repeat (4) @(negedge i_clk_sys);
		check("locked", o_dll_locked, 16'h0000);
		i_div_reset = 0;
		xfer(8'h01, 1'b1, 8'hB6, 8'h00);
		check("status", o_rdata, 16'h0000);
		n = 0;
		while (o_dll_locked !== 1'b1 && n < 2000) begin
			@(negedge i_clk_sys);
			n++;
		end
		if (n >= 2000) begin
			bad_count++;
			give_verdict();
		end
		check("recover", dll_n >= 1298 && dll_n <= 1304, 16'h0001);
		lat_on = 0;
		@(negedge i_clk_sys);
		i_rst_b = 0;
		@(negedge i_clk_sys);
		check("reset", {o_busy, o_done, o_dll_locked, ast_if_inst.port_select_n,
			ast_if_inst.sclk, o_cfg}, 16'h0600);
		i_rst_b = 1;
		repeat (2) @(negedge i_clk_sys);
		check("after reset", {o_busy, o_done, o_dll_locked, ast_if_inst.port_select_n,
			ast_if_inst.sclk, o_cfg}, 16'h0600);
		xfer(8'h01, 1'b1, ast_pkg::ADDR_STATUS, 8'h00);
		check("status again", o_rdata, 16'h0001);
		give_verdict();
	end
endmodule : adc_spi_timing_and_latency_test

// ===== ast_asserts.sv
// Purpose: wire checks on the config port between the two ends
// Assumes: a rw bit of 1 marks a read frame
// Notes: setup and hold limits are lower bounds at scale 1 and so hold at any scale
module ast_asserts (
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	input wire logic port_select_n,
	input wire logic sclk,
	input wire logic sdio,
	input wire logic sdio_host_oe_n,
	input wire logic sdio_dev_oe_n
);
	// ****
	// helper counters
	// ****
	logic [7:0] sel_reg, rise_reg, fall_reg, stab_reg, bits_reg;
	logic rd_reg;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_b);
	// saturate so a long idle never wraps into a false failure
	function automatic logic [7:0] inc(input logic [7:0] v);
		return v + {7'h00, v != 8'hFF};
	endfunction : inc
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			{sel_reg, rise_reg, fall_reg, stab_reg, bits_reg, rd_reg} <= '0;
		end else begin
			sel_reg <= port_select_n ? 8'h00 : inc(sel_reg);
			rise_reg <= $rose(sclk) ? 8'h01 : inc(rise_reg);
			fall_reg <= $fell(sclk) ? 8'h01 : inc(fall_reg);
			stab_reg <= $changed(sdio) ? 8'h01 : inc(stab_reg);
			bits_reg <= port_select_n ? 8'h00 : bits_reg + {7'h00, $rose(sclk)};
			rd_reg <= (!port_select_n && bits_reg == 8'h00) ? sdio : rd_reg;
		end
	end
	// ****
	// properties
	// ****
	sequence s_rd_launch;
		$fell(sclk) && rd_reg && bits_reg >= 8'h09;
	endsequence
	sequence s_dev_drives;
		##[0:5] (!sdio_dev_oe_n && sdio_host_oe_n);
	endsequence
	chk_cs_setup: assert property ($rose(sclk) |-> sel_reg >= 8'h1C)
		else $error("select setup too short");
	chk_wr_hold: assert property ($rose(port_select_n) && !rd_reg |-> rise_reg >= 8'h05)
		else $error("write select hold too short");
	chk_rd_hold: assert property ($rose(port_select_n) && rd_reg |-> fall_reg >= 8'h10)
		else $error("read select hold too short");
	chk_data_setup: assert property ($rose(sclk) && !rd_reg |-> stab_reg >= 8'h06)
		else $error("write data setup too short");
	chk_rd_valid: assert property (s_rd_launch |-> s_dev_drives)
		else $error("read bit not driven in time");
	chk_host_release: assert property (rd_reg && bits_reg >= 8'h0A |-> sdio_host_oe_n)
		else $error("host drives during read data");
	chk_wr_quiet: assert property (!port_select_n && !rd_reg && bits_reg != 8'h00 |-> sdio_dev_oe_n)
		else $error("device drives in write frame");
	chk_frame_bits: assert property ($rose(port_select_n) |-> bits_reg == 8'h11)
		else $error("frame bit count wrong");
	chk_sclk_idle: assert property (port_select_n |-> !sclk)
		else $error("serial clock moves while idle");
endmodule : ast_asserts

// ===== ast_dev.sv
// Purpose: converter end: config port, divider reset, pipeline latency
// Assumes: port pins arrive asynchronous and are synchronised here
// Notes: one 8-bit config store per address is not modelled, one register only
// ****************************************
// converter end
// ****************************************
// What this block does
// RULE1 - limits counted in sample periods, 4ns reference
// RULE2 - host stretches limits for slower sample rate
// RULE3 - host accesses only while sample clock runs
// RULE4 - port serial clock may be asynchronous
// RULE5 - select low 28 periods before clock
// RULE6 - write: select held 5 periods after rise
// RULE7 - read: select held 16 periods after fall
// RULE8 - write data set 6 periods before rise
// RULE9 - read bit valid within 5 periods
// RULE10 - divider reset sampled on sample clock rise
// RULE11 - dll recovers 52 us after divider reset
// RULE12 - samples emerge 10 cycles after conversion
// RULE13 - host scales intervals by programmable period count
module ast_dev (
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	ast_if.dev link,
	input wire logic [13:0] i_sample,
	output logic [13:0] o_sample,
	output logic [7:0] o_cfg,
	output logic o_cfg_wr,
	output logic o_dll_locked
);
	localparam int DLL_W = 16;
	// ****************************************
	// synchronisers
	// ****************************************
	logic [2:0] cs_sync_reg;
	logic [2:0] sck_sync_reg;
	logic [1:0] sdi_sync_reg;
	logic rst_sync_reg;
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cs_sync_reg <= 3'h7;
			sck_sync_reg <= 3'h0;
			sdi_sync_reg <= 2'h0;
		end else begin
			cs_sync_reg <= {cs_sync_reg[1:0], link.port_select_n}; // RULE4
			sck_sync_reg <= {sck_sync_reg[1:0], link.sclk}; // RULE4
			sdi_sync_reg <= {sdi_sync_reg[0], link.sdio};
		end
	end
	wire cs_active = !cs_sync_reg[1];
	wire sck_rise = sck_sync_reg[1] && !sck_sync_reg[2];
	wire sck_fall = !sck_sync_reg[1] && sck_sync_reg[2];
	// ****************************************
	// serial frame: rw, address, data
	// ****************************************
	logic [4:0] bit_cnt_reg;
	logic [ast_pkg::FRAME_BITS-2:0] shift_reg;
	logic rd_reg;
	logic [7:0] cfg_reg;
	logic cfg_wr_reg;
	logic sdo_reg;
	logic sdo_oe_n_reg;
	wire in_addr = bit_cnt_reg < 5'(1 + ast_pkg::ADDR_BITS);
	wire last_bit = bit_cnt_reg == 5'(ast_pkg::FRAME_BITS - 1);
	wire [7:0] rd_word = (shift_reg[7:0] == ast_pkg::ADDR_STATUS) ?
		{7'h00, o_dll_locked} : cfg_reg;
	wire [2:0] rd_idx = 3'(bit_cnt_reg - 5'(1 + ast_pkg::ADDR_BITS));
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			bit_cnt_reg <= 5'h00;
			shift_reg <= '0;
			rd_reg <= 1'b0;
			cfg_reg <= 8'h00;
			cfg_wr_reg <= 1'b0;
			sdo_reg <= 1'b1;
			sdo_oe_n_reg <= 1'b1;
		end else begin
			cfg_wr_reg <= 1'b0;
			if (!cs_active) begin
				bit_cnt_reg <= 5'h00;
				sdo_oe_n_reg <= 1'b1;
			end else if (sck_rise) begin
				// capture on rise; host met the data setup
				if (bit_cnt_reg == 5'h00)
					rd_reg <= sdi_sync_reg[1]; // RULE8
				else if (in_addr || !rd_reg)
					shift_reg <= {shift_reg[ast_pkg::FRAME_BITS-3:0], sdi_sync_reg[1]};
				if (last_bit && !rd_reg) begin
					cfg_reg <= {shift_reg[6:0], sdi_sync_reg[1]};
					cfg_wr_reg <= 1'b1;
				end
				if (!last_bit)
					bit_cnt_reg <= bit_cnt_reg + 5'h01;
			end else if (sck_fall && rd_reg && !in_addr) begin
				// launched 3 clocks after the pin edge, within the valid limit
				sdo_reg <= rd_word[3'h7 - rd_idx]; // RULE9
				sdo_oe_n_reg <= 1'b0;
			end
		end
	end
	assign link.sdio_dev_o = sdo_reg;
	assign link.sdio_dev_oe_n = sdo_oe_n_reg;
	assign o_cfg = cfg_reg;
	assign o_cfg_wr = cfg_wr_reg;
	// ****************************************
	// divider reset and dll recovery
	// ****************************************
	logic [DLL_W-1:0] dll_cnt_reg;
	logic dll_locked_reg;
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rst_sync_reg <= 1'b0;
			dll_cnt_reg <= '0;
			dll_locked_reg <= 1'b1;
		end else begin
			rst_sync_reg <= link.divider_sync_reset_pos; // RULE10
			if (rst_sync_reg) begin
				dll_cnt_reg <= DLL_W'(ast_pkg::DLL_RECOVER_CYCLES); // RULE11
				dll_locked_reg <= 1'b0;
			end else if (dll_cnt_reg != '0) begin
				dll_cnt_reg <= dll_cnt_reg - DLL_W'(1);
				dll_locked_reg <= dll_cnt_reg == DLL_W'(1);
			end
		end
	end
	assign o_dll_locked = dll_locked_reg;
	// ****************************************
	// pipeline latency
	// ****************************************
	logic [13:0] pipe_reg [ast_pkg::LATENCY_CYCLES];
	genvar g;
	generate
		for (g = 0; g < ast_pkg::LATENCY_CYCLES; g++) begin : g_pipe
			always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
				if (!i_rst_b)
					pipe_reg[g] <= 14'h0000;
				else if (g == 0)
					pipe_reg[g] <= i_sample; // RULE12
				else
					pipe_reg[g] <= pipe_reg[(g == 0) ? 0 : g - 1];
			end
		end
	endgenerate
	assign o_sample = pipe_reg[ast_pkg::LATENCY_CYCLES-1];
endmodule : ast_dev

// ===== ast_host.sv
// Purpose: host end: drives framed reads and writes on the config port
// Assumes: every timing interval is a multiple of a programmable scale
// Notes: the system clock must keep running during a frame
module ast_host (
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	ast_if.host link,
	input wire logic [7:0] i_scale,
	input wire logic i_start,
	input wire logic i_read,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_div_reset,
	output logic o_busy,
	output logic o_done,
	output logic [7:0] o_rdata
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000, ST_SETUP = 3'b001, ST_LOW = 3'b010,
		ST_HIGH = 3'b011, ST_HOLD = 3'b100
	} ast_state_t;
	ast_state_t state_reg;
	logic [15:0] wait_reg;
	logic [4:0] bit_reg;
	logic [16:0] tx_reg;
	logic rd_reg;
	logic [7:0] rdata_reg;
	logic cs_n_reg, sck_reg, sdo_reg, oe_n_reg, done_reg, busy_reg, dvr_reg;
	// interval in clocks = periods * scale
	function automatic logic [15:0] span(input logic [7:0] periods, input logic [7:0] s);
		span = periods * s; // RULE13 RULE1 RULE2
	endfunction : span
	wire [7:0] half = rd_reg ? (ast_pkg::RD_SCLK_PERIODS >> 1) :
		((ast_pkg::WR_SCLK_PERIODS + 8'h01) >> 1);
	wire [7:0] low_p = (half > ast_pkg::DATA_SETUP_PERIODS) ? half : ast_pkg::DATA_SETUP_PERIODS;
	wire [7:0] high_p = (rd_reg && half <= ast_pkg::RD_VALID_PERIODS) ?
		ast_pkg::RD_VALID_PERIODS + 8'h01 : half;
	wire wait_done = wait_reg <= 16'h0001;
	wire last = bit_reg == 5'(ast_pkg::FRAME_BITS - 1);
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_reg <= ST_IDLE;
			wait_reg <= 16'h0000;
			bit_reg <= 5'h00;
			tx_reg <= '0;
			rd_reg <= 1'b0;
			rdata_reg <= 8'h00;
			cs_n_reg <= 1'b1;
			sck_reg <= 1'b0;
			sdo_reg <= 1'b1;
			oe_n_reg <= 1'b1;
			done_reg <= 1'b0;
			busy_reg <= 1'b0;
			dvr_reg <= 1'b0;
		end else begin
			done_reg <= 1'b0;
			dvr_reg <= i_div_reset;
			if (wait_reg != 16'h0000)
				wait_reg <= wait_reg - 16'h0001;
			case (state_reg)
				ST_IDLE: begin
					if (i_start) begin
						rd_reg <= i_read;
						tx_reg <= {i_read, i_addr, i_wdata};
						cs_n_reg <= 1'b0;
						busy_reg <= 1'b1;
						oe_n_reg <= 1'b0;
						sdo_reg <= i_read;
						bit_reg <= 5'h00;
						wait_reg <= span(ast_pkg::CS_SETUP_PERIODS, i_scale); // RULE5
						state_reg <= ST_SETUP;
					end
				end
				ST_SETUP, ST_LOW: begin
					if (wait_done) begin
						sck_reg <= 1'b1;
						wait_reg <= span(high_p, i_scale);
						state_reg <= ST_HIGH;
					end
				end
				ST_HIGH: begin
					if (wait_done) begin
						sck_reg <= 1'b0;
						if (rd_reg && bit_reg > 5'(ast_pkg::ADDR_BITS))
							rdata_reg <= {rdata_reg[6:0], link.sdio}; // RULE9
						if (last) begin
							// write hold and read hold both counted from the last fall
							wait_reg <= rd_reg ? span(ast_pkg::RD_HOLD_PERIODS, i_scale) // RULE7
								: span(ast_pkg::WR_HOLD_PERIODS, i_scale); // RULE6
							state_reg <= ST_HOLD;
						end else begin
							bit_reg <= bit_reg + 5'h01;
							tx_reg <= {tx_reg[15:0], 1'b0};
							sdo_reg <= tx_reg[15]; // RULE8
							oe_n_reg <= rd_reg && bit_reg >= 5'(ast_pkg::ADDR_BITS);
							wait_reg <= span(low_p, i_scale);
							state_reg <= ST_LOW;
						end
					end
				end
				ST_HOLD: begin
					oe_n_reg <= 1'b1;
					if (wait_done) begin
						cs_n_reg <= 1'b1;
						busy_reg <= 1'b0;
						done_reg <= 1'b1;
						state_reg <= ST_IDLE;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end
	assign link.port_select_n = cs_n_reg;
	assign link.sclk = sck_reg;
	assign link.sdio_host_o = sdo_reg;
	assign link.sdio_host_oe_n = oe_n_reg;
	assign link.divider_sync_reset_pos = dvr_reg;
	assign o_busy = busy_reg;
	assign o_done = done_reg;
	assign o_rdata = rdata_reg;
endmodule : ast_host

// ===== ast_if.sv
// Purpose: wires between the converter port and its host
// Assumes: sdio is resolved from the enables here
// Notes: output enables are active low
interface ast_if;
	logic port_select_n;
	logic sclk;
	logic sdio_host_o;
	logic sdio_host_oe_n;
	logic sdio_dev_o;
	logic sdio_dev_oe_n;
	logic sdio;
	logic divider_sync_reset_pos;
	assign sdio = !sdio_host_oe_n ? sdio_host_o : (!sdio_dev_oe_n ? sdio_dev_o : 1'b1);
	modport host (output port_select_n, output sclk, output sdio_host_o,
		output sdio_host_oe_n, input sdio, output divider_sync_reset_pos);
	modport dev (input port_select_n, input sclk, output sdio_dev_o,
		output sdio_dev_oe_n, input sdio, input divider_sync_reset_pos);
endinterface : ast_if

// ===== ast_pkg.sv
// Purpose: shared constants for the serial configuration port and its host
// Assumes: one system clock at 25 MHz stands in for the converter sample clock
// Notes: all port limits are counts of sample periods
package ast_pkg;
	// ****************************************
	// timing: port limits in sample periods, clock periods in ns, dll recovery in us
	// ****************************************
	localparam int REF_PERIOD_NS = 4;
	localparam int CLK_NS = 40;
	localparam logic [7:0] CS_SETUP_PERIODS = 8'h1C;
	localparam logic [7:0] WR_HOLD_PERIODS = 8'h05;
	localparam logic [7:0] RD_HOLD_PERIODS = 8'h10;
	localparam logic [7:0] DATA_SETUP_PERIODS = 8'h06;
	localparam logic [7:0] RD_VALID_PERIODS = 8'h05;
	localparam logic [7:0] WR_SCLK_PERIODS = 8'h07;
	localparam logic [7:0] RD_SCLK_PERIODS = 8'h10;
	localparam int LATENCY_CYCLES = 10;
	localparam int DLL_RECOVER_US = 52;
	localparam int DLL_RECOVER_CYCLES = (DLL_RECOVER_US * 1000) / CLK_NS;
	// ****************************************
	// frame layout
	// ****************************************
	localparam int ADDR_BITS = 8;
	localparam int DATA_BITS = 8;
	localparam int FRAME_BITS = 1 + ADDR_BITS + DATA_BITS;
	localparam logic [7:0] SCALE_RESET = 8'h01;
	localparam logic [ADDR_BITS-1:0] ADDR_STATUS = 8'hB6;
endpackage : ast_pkg
